// *** rtl/fac_flash_ctrl.sv ***
// flash array controller: lock, program, erase and read guarding
`default_nettype none
module fac_flash_ctrl
  import fac_pkg::*;
#(
  parameter int MEM_BYTES = MEM_BYTES_DEF
) (
  input  wire logic        MCLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic        CTRL_WR_I,
  input  wire logic        FREQ_HI_WR_I,
  input  wire logic        FREQ_LO_WR_I,
  input  wire logic [7:0]  DATA_I,
  input  wire logic [7:0]  PAGE_SEL_I,
  input  wire logic [7:0]  SECTOR_PROTECT_I,
  input  wire logic        DEBUG_I,
  input  wire logic        PROG_WR_I,
  input  wire logic        RD_I,
  input  wire logic [15:0] ADDR_I,
  input  wire logic        READOUT_PROTECT_OPTION_I,
  input  wire logic [7:0]  FLASH_RDATA_I,
  output var  logic [15:0] FLASH_ADDR_O,
  output var  logic [7:0]  FLASH_CLR_MASK_O,
  output var  logic        FLASH_PROG_O,
  output var  logic        FLASH_PAGE_ERASE_O,
  output var  logic        FLASH_MASS_ERASE_O,
  output var  logic [7:0]  RD_DATA_O,
  output var  logic        RD_VALID_O,
  output var  logic        BUSY_O,
  output var  logic        LOCKED_O,
  output var  logic        REFUSED_O
);
  // ------------------------------------------------------------
  // geometry helpers
  // ------------------------------------------------------------
  localparam int SECTOR_BYTES =
    (MEM_BYTES == MEM_MAX) ? SECTOR_BIG : PAGE_BYTES;
  localparam int PAGES = MEM_BYTES / PAGE_BYTES;

  function automatic logic in_user(input logic [15:0] a);
    in_user = (32'(a) < MEM_BYTES);
  endfunction

  function automatic logic in_info(input logic [15:0] a);
    in_info = (a >= INFO_BASE) && (a <= INFO_TOP);
  endfunction

  function automatic logic [6:0] page_of(input logic [15:0] a);
    page_of = a[15:PAGE_LSB];
  endfunction

  // row within page, handed to the array with the low address bits
  function automatic logic [2:0] row_of(input logic [15:0] a);
    row_of = a[PAGE_LSB-1:ROW_LSB];
  endfunction

  function automatic logic sect_prot(input logic [6:0] pg,
                                     input logic [7:0] prot);
    int idx;
    idx = (32'(pg) * PAGE_BYTES) / SECTOR_BYTES;
    sect_prot = prot[idx[2:0]];
  endfunction

  // least times round up, never below one cycle
  function automatic logic [31:0] cyc_us(input logic [15:0] khz);
    logic [31:0] c;
    c = (32'(khz) * PROG_TIME_US + KHZ_DIV - 1) / KHZ_DIV;
    cyc_us = (c == 32'h0) ? 32'h1 : c;
  endfunction

  function automatic logic [31:0] cyc_ms(input logic [15:0] khz,
                                        input int ms);
    logic [31:0] c;
    c = 32'(khz) * 32'(ms);
    cyc_ms = (c == 32'h0) ? 32'h1 : c;
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    fac_state_t  state;
    logic [15:0] khz;
    logic        hi_ok;
    logic        lo_ok;
    logic [6:0]  page;
    logic [31:0] cnt;
    logic [15:0] addr;
    logic [7:0]  clr;
    logic        prog;
    logic        perase;
    logic        merase;
    logic        rd_pend;
    logic        rd_block;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        busy;
    logic        locked;
    logic        refused;
  } fac_regs_t;

  fac_regs_t s_reg;
  fac_regs_t s_next;
  logic      freq_ok;
  logic      page_ok;

  assign freq_ok = s_reg.hi_ok && s_reg.lo_ok;
  assign page_ok = (32'(PAGE_SEL_I) < PAGES);

  always_comb begin
    s_next          = s_reg;
    s_next.rd_valid = 1'b0;
    s_next.refused  = 1'b0;
    // reads of the array, also from the information area
    if (s_reg.rd_pend) begin
      s_next.rd_pend  = 1'b0;
      s_next.rd_valid = 1'b1;
      s_next.rd_data  = s_reg.rd_block ? DENIED_BYTE : FLASH_RDATA_I;
    end else if (RD_I && !s_reg.busy) begin
      s_next.addr     = ADDR_I;
      s_next.rd_pend  = 1'b1;
      // option bytes stay visible so the debugger can see the setting
      s_next.rd_block = DEBUG_I && READOUT_PROTECT_OPTION_I &&
                        in_user(ADDR_I) &&
                        (32'(ADDR_I) >= OPTION_BYTES);
    end
    // frequency bytes are frozen while an operation runs
    if (!s_reg.busy && FREQ_HI_WR_I) begin
      s_next.khz[15:8] = DATA_I;
      s_next.hi_ok     = 1'b1;
    end
    if (!s_reg.busy && FREQ_LO_WR_I) begin
      s_next.khz[7:0] = DATA_I;
      s_next.lo_ok    = 1'b1;
    end
    unique case (s_reg.state)
      FAC_LOCKED: begin
        if (CTRL_WR_I && DATA_I == CMD_UNLOCK1) begin
          s_next.state = FAC_UNLOCK1;
        end
      end
      FAC_UNLOCK1: begin
        if (CTRL_WR_I) begin
          if (DATA_I == CMD_UNLOCK2 && page_ok) begin
            s_next.state = FAC_UNLOCKED;
            s_next.page  = PAGE_SEL_I[6:0];
          end else begin
            s_next.state = FAC_LOCKED;
          end
        end
      end
      FAC_UNLOCKED: begin
        if (CTRL_WR_I) begin
          s_next.state = FAC_LOCKED;
          if (DATA_I == CMD_PAGE_ERASE) begin
            if (freq_ok && (DEBUG_I ||
                !sect_prot(s_reg.page, SECTOR_PROTECT_I))) begin
              s_next.state  = FAC_ERASE;
              s_next.perase = 1'b1;
              s_next.addr   = {s_reg.page, 9'h000};
              s_next.cnt    = cyc_ms(s_reg.khz, PAGE_ERASE_MS);
            end else begin
              s_next.refused = 1'b1;
            end
          end else if (DATA_I == CMD_MASS_ERASE) begin
            // mass erase is a debugger privilege only
            if (DEBUG_I && freq_ok) begin
              s_next.state  = FAC_ERASE;
              s_next.merase = 1'b1;
              s_next.addr   = 16'h0000;
              s_next.cnt    = cyc_ms(s_reg.khz, MASS_ERASE_MS);
            end else begin
              s_next.refused = 1'b1;
            end
          end
        end else if (PROG_WR_I) begin
          if (freq_ok && in_user(ADDR_I) && !in_info(ADDR_I) &&
              page_of(ADDR_I) == s_reg.page &&
              (DEBUG_I || !sect_prot(s_reg.page, SECTOR_PROTECT_I))) begin
            s_next.state = FAC_PROG;
            s_next.prog  = 1'b1;
            s_next.addr  = {ADDR_I[15:PAGE_LSB], row_of(ADDR_I),
                            ADDR_I[ROW_LSB-1:0]};
            s_next.clr   = ~DATA_I;
            s_next.cnt   = cyc_us(s_reg.khz);
          end else begin
            s_next.refused = 1'b1;
          end
        end
      end
      FAC_PROG: begin
        s_next.cnt = s_reg.cnt - 32'h1;
        if (s_reg.cnt == 32'h1) begin
          s_next.prog  = 1'b0;
          s_next.clr   = 8'h00;
          s_next.state = FAC_UNLOCKED;
        end
      end
      FAC_ERASE: begin
        s_next.cnt = s_reg.cnt - 32'h1;
        if (s_reg.cnt == 32'h1) begin
          s_next.perase = 1'b0;
          s_next.merase = 1'b0;
          s_next.state  = FAC_LOCKED;
        end
      end
    endcase
    s_next.busy   = (s_next.state == FAC_PROG) ||
                    (s_next.state == FAC_ERASE);
    s_next.locked = (s_next.state == FAC_LOCKED) ||
                    (s_next.state == FAC_UNLOCK1);
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      s_reg        <= '0;
      s_reg.state  <= FAC_LOCKED;
      s_reg.khz    <= KHZ_RESET;
      s_reg.locked <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign FLASH_ADDR_O       = s_reg.addr;
  assign FLASH_CLR_MASK_O   = s_reg.clr;
  assign FLASH_PROG_O       = s_reg.prog;
  assign FLASH_PAGE_ERASE_O = s_reg.perase;
  assign FLASH_MASS_ERASE_O = s_reg.merase;
  assign RD_DATA_O          = s_reg.rd_data;
  assign RD_VALID_O         = s_reg.rd_valid;
  assign BUSY_O             = s_reg.busy;
  assign LOCKED_O           = s_reg.locked;
  assign REFUSED_O          = s_reg.refused;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  // second unlock byte may come any number of cycles after the first
  sequence s_unlock;
    s_reg.state == FAC_UNLOCK1 && CTRL_WR_I &&
    DATA_I == CMD_UNLOCK2 && page_ok;
  endsequence

  sequence s_erase_cmd;
    s_reg.state == FAC_UNLOCKED && CTRL_WR_I &&
    DATA_I == CMD_PAGE_ERASE && !DEBUG_I;
  endsequence

  a_reset_locks: assert property (@(posedge MCLK_I)
    !RESET_N_I |=> LOCKED_O && !BUSY_O)
    else $error("not locked after reset");

  a_unlock_seq: assert property (@(posedge MCLK_I)
    disable iff (!RESET_N_I) s_unlock |=> !LOCKED_O)
    else $error("unlock sequence did not unlock");

  a_erase_relock: assert property (@(posedge MCLK_I)
    disable iff (!RESET_N_I) $fell(FLASH_PAGE_ERASE_O) |-> LOCKED_O)
    else $error("page erase did not end locked");

  a_protect_sector: assert property (@(posedge MCLK_I)
    disable iff (!RESET_N_I)
    s_erase_cmd and sect_prot(s_reg.page, SECTOR_PROTECT_I)
    |=> REFUSED_O && !FLASH_PAGE_ERASE_O && LOCKED_O)
    else $error("erase of protected sector started");

  a_clear_only: assert property (@(posedge MCLK_I)
    disable iff (!RESET_N_I)
    $rose(FLASH_PROG_O) |-> FLASH_CLR_MASK_O == ~$past(DATA_I))
    else $error("program mask not inverse of data");

  a_prog_page: assert property (@(posedge MCLK_I)
    disable iff (!RESET_N_I)
    $rose(FLASH_PROG_O) |-> page_of(FLASH_ADDR_O) == s_reg.page)
    else $error("program outside active page");

  a_info_refused: assert property (@(posedge MCLK_I)
    disable iff (!RESET_N_I)
    s_reg.state == FAC_UNLOCKED && !CTRL_WR_I && PROG_WR_I &&
    in_info(ADDR_I) |=> REFUSED_O && !FLASH_PROG_O)
    else $error("information area write accepted");

  a_readout_block: assert property (@(posedge MCLK_I)
    disable iff (!RESET_N_I)
    RD_I && !BUSY_O && !s_reg.rd_pend && DEBUG_I &&
    READOUT_PROTECT_OPTION_I && in_user(ADDR_I) &&
    32'(ADDR_I) >= OPTION_BYTES
    |=> ##1 RD_VALID_O && RD_DATA_O == DENIED_BYTE)
    else $error("protected code returned to debugger");

  a_khz_load: assert property (@(posedge MCLK_I)
    disable iff (!RESET_N_I)
    FREQ_HI_WR_I && !BUSY_O |=> s_reg.khz[15:8] == $past(DATA_I))
    else $error("frequency high byte not taken");

  a_pulse_holds: assert property (@(posedge MCLK_I)
    disable iff (!RESET_N_I)
    s_reg.state == FAC_PROG && s_reg.cnt > 32'h1 |=> FLASH_PROG_O)
    else $error("program pulse ended early");
endmodule
`default_nettype wire

// *** rtl/fac_pkg.sv ***
// constants shared by the flash array controller
`default_nettype none
package fac_pkg;
  // ------------------------------------------------------------
  // array geometry
  // ------------------------------------------------------------
  localparam int PAGE_BYTES    = 512;
  localparam int ROW_BYTES     = 64;
  localparam int ROWS_PER_PAGE = 8;
  localparam int SECTOR_BIG    = 1024;
  localparam int MEM_MAX       = 8192;
  localparam int MEM_BYTES_DEF = 8192;
  localparam int OPTION_BYTES  = 2;
  localparam int PAGE_LSB      = 9;
  localparam int ROW_LSB       = 6;
  localparam logic [15:0] INFO_BASE = 16'hfe00;
  localparam logic [15:0] INFO_TOP  = 16'hffff;
  localparam logic [7:0]  ERASED_BYTE = 8'hff;
  localparam logic [7:0]  DENIED_BYTE = 8'h00;

  // ------------------------------------------------------------
  // control write codes
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_UNLOCK1    = 8'h73;
  localparam logic [7:0] CMD_UNLOCK2    = 8'h8c;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h63;

  // ------------------------------------------------------------
  // timing, scaled at run time from the khz setting
  // ------------------------------------------------------------
  localparam int KHZ_DIV       = 1000;
  localparam int PROG_TIME_US  = 40;
  localparam int PAGE_ERASE_MS = 10;
  localparam int MASS_ERASE_MS = 200;
  localparam logic [15:0] KHZ_RESET = 16'h0000;

  typedef enum logic [2:0] {
    FAC_LOCKED,
    FAC_UNLOCK1,
    FAC_UNLOCKED,
    FAC_PROG,
    FAC_ERASE
  } fac_state_t;
endpackage
`default_nettype wire

// *** test/fac_flash_model.sv ***
// behavioural flash array that sits behind the controller
`default_nettype none
module fac_flash_model
  import fac_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  clr_mask_i,
  input  wire logic        prog_i,
  input  wire logic        page_erase_i,
  input  wire logic        mass_erase_i,
  output var  logic [7:0]  rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // array contents
  // ------------------------------------------------------------
  logic [7:0] mem [0:65535];
  logic       pe_q;
  logic       me_q;
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i) ^ 8'ha5;
    end
  end
  // read path has no latency, as the controller expects
  assign rdata_o = mem[addr_i];
  // erase once per pulse: a loop every cycle of a long pulse is too slow
  always @(posedge clk_i) begin
    pe_q <= page_erase_i;
    me_q <= mass_erase_i;
    if (prog_i) begin
      mem[addr_i] <= mem[addr_i] & ~clr_mask_i;
    end
    if (page_erase_i && !pe_q) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        mem[{addr_i[15:9], 9'(i)}] <= ERASED_BYTE;
      end
    end
    // information area lies above user memory and is never touched
    if (mass_erase_i && !me_q) begin
      for (int i = 0; i < MEM_MAX; i++) begin
        mem[i] <= ERASED_BYTE;
      end
    end
  end
endmodule
`default_nettype wire

// *** test/fac_flash_ctrl_tb.sv ***
// self-checking bench for the flash array controller
`default_nettype none
module fac_flash_ctrl_tb
  import fac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int KHZ = 258;
  // lowest khz setting that still lies inside the supported clock range
  localparam int KHZ_LOW = 33;
  logic        clk, rst_n, ctrl_wr, fhi_wr, flo_wr, debug, prog_wr, rd;
  logic        ro_opt, fprog, perase, merase, rd_valid, busy, locked;
  logic        refused, s_busy, s_ref, s_lock, s_prog, s_pe, s_me;
  logic [7:0]  data, page_sel, sect_prot, frdata, rd_data, clr_mask;
  logic [7:0]  s_mask;
  logic [15:0] addr, faddr, s_addr;
  int          err_total, check_count;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  fac_flash_ctrl u_fac_flash_ctrl (
    .MCLK_I(clk), .RESET_N_I(rst_n), .CTRL_WR_I(ctrl_wr),
    .FREQ_HI_WR_I(fhi_wr), .FREQ_LO_WR_I(flo_wr), .DATA_I(data),
    .PAGE_SEL_I(page_sel), .SECTOR_PROTECT_I(sect_prot),
    .DEBUG_I(debug), .PROG_WR_I(prog_wr), .RD_I(rd), .ADDR_I(addr),
    .READOUT_PROTECT_OPTION_I(ro_opt), .FLASH_RDATA_I(frdata),
    .FLASH_ADDR_O(faddr), .FLASH_CLR_MASK_O(clr_mask),
    .FLASH_PROG_O(fprog), .FLASH_PAGE_ERASE_O(perase),
    .FLASH_MASS_ERASE_O(merase), .RD_DATA_O(rd_data),
    .RD_VALID_O(rd_valid), .BUSY_O(busy), .LOCKED_O(locked),
    .REFUSED_O(refused));
  fac_flash_model u_fac_flash_model (
    .clk_i(clk), .addr_i(faddr), .clr_mask_i(clr_mask), .prog_i(fprog),
    .page_erase_i(perase), .mass_erase_i(merase), .rdata_o(frdata));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  function automatic logic [7:0] init_val(input logic [15:0] a);
    return a[7:0] ^ 8'ha5;
  endfunction
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // kind 0 control, 1 khz high, 2 khz low, 3 byte program
  task automatic strobe(input int kind, input logic [7:0] d);
    {ctrl_wr, fhi_wr, flo_wr, prog_wr} = 4'(4'h8 >> kind);
    data = d;
    @(negedge clk);
    // snapshot here: refusal is a one-cycle pulse
    {s_busy, s_ref, s_lock} = {busy, refused, locked};
    {s_prog, s_pe, s_me} = {fprog, perase, merase};
    s_addr = faddr;
    s_mask = clr_mask;
    {ctrl_wr, fhi_wr, flo_wr, prog_wr} = 4'h0;
    @(negedge clk);
  endtask
  task automatic unlock(input logic [7:0] p);
    page_sel = p;
    strobe(0, CMD_UNLOCK1);
    strobe(0, CMD_UNLOCK2);
  endtask
  task automatic wait_busy(input int exp);
    int n;
    n = 1;
    while (busy === 1'b1 && n < 60000) begin
      n++;
      @(negedge clk);
    end
    if (n >= 60000) begin
      err_total++;
      print_verdict();
    end
    chk("busy cycles", 16'(exp), 16'(n));
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    chk("read valid", 16'h1, {15'h0, rd_valid});
    chk("read data", {8'h0, exp}, {8'h0, rd_data});
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic s_lock_seq();
    chk("locked", 16'h1, {15'h0, locked});
    page_sel = 8'h01;
    strobe(0, CMD_UNLOCK1);
    strobe(0, 8'h12);
    strobe(0, CMD_UNLOCK2);
    chk("locked", 16'h1, {15'h0, s_lock});
    unlock(8'h01);
    chk("locked", 16'h0, {15'h0, s_lock});
    strobe(0, CMD_PAGE_ERASE);
    chk("refused", 16'h1, {15'h0, s_ref});
    chk("locked", 16'h1, {15'h0, s_lock});
  endtask
  task automatic s_program();
    strobe(1, 8'h01);
    unlock(8'h01);
    strobe(0, CMD_PAGE_ERASE);
    chk("refused", 16'h1, {15'h0, s_ref});
    strobe(2, 8'h02);
    unlock(8'h01);
    addr = 16'h0210;
    strobe(3, 8'h0f);
    chk("prog pulse", 16'h1, {15'h0, s_prog});
    chk("prog addr", 16'h0210, s_addr);
    chk("prog mask", 16'h00f0, {8'h0, s_mask});
    wait_busy((KHZ * PROG_TIME_US + KHZ_DIV - 1) / KHZ_DIV);
    addr = 16'h0410;
    strobe(3, 8'h00);
    chk("refused", 16'h1, {15'h0, s_ref});
    addr = 16'hfe10;
    strobe(3, 8'h00);
    chk("refused", 16'h1, {15'h0, s_ref});
    chk("locked", 16'h0, {15'h0, locked});
    strobe(0, 8'h00);
    rd_chk(16'h0210, init_val(16'h0210) & 8'h0f);
    rd_chk(16'hfe10, init_val(16'hfe10));
  endtask
  task automatic s_erase();
    unlock(8'h01);
    strobe(0, CMD_PAGE_ERASE);
    chk("erase pulse", 16'h1, {15'h0, s_pe});
    chk("erase addr", 16'h0200, s_addr);
    wait_busy(KHZ * PAGE_ERASE_MS);
    chk("locked", 16'h1, {15'h0, locked});
    rd_chk(16'h0210, ERASED_BYTE);
    rd_chk(16'h03ff, ERASED_BYTE);
    rd_chk(16'h01ff, init_val(16'h01ff));
    rd_chk(16'h0400, init_val(16'h0400));
  endtask
  task automatic s_sector();
    sect_prot = 8'h02;
    unlock(8'h03);
    strobe(0, CMD_PAGE_ERASE);
    chk("refused", 16'h1, {15'h0, s_ref});
    chk("busy", 16'h0, {15'h0, s_busy});
    unlock(8'h04);
    strobe(0, CMD_PAGE_ERASE);
    chk("busy", 16'h1, {15'h0, s_busy});
    wait_busy(KHZ * PAGE_ERASE_MS);
    rd_chk(16'h0600, init_val(16'h0600));
    rd_chk(16'h0800, ERASED_BYTE);
    sect_prot = 8'h00;
  endtask
  task automatic s_readout();
    ro_opt = 1'b1;
    rd_chk(16'h0100, init_val(16'h0100));
    debug = 1'b1;
    rd_chk(16'h0100, DENIED_BYTE);
    rd_chk(16'h0001, init_val(16'h0001));
    ro_opt = 1'b0;
    rd_chk(16'h0100, init_val(16'h0100));
    debug = 1'b0;
  endtask
  task automatic s_mass();
    strobe(1, 8'h00);
    strobe(2, 8'(KHZ_LOW));
    unlock(8'h00);
    strobe(0, CMD_MASS_ERASE);
    chk("refused", 16'h1, {15'h0, s_ref});
    debug = 1'b1;
    unlock(8'h00);
    strobe(0, CMD_MASS_ERASE);
    chk("mass pulse", 16'h1, {15'h0, s_me});
    wait_busy(KHZ_LOW * MASS_ERASE_MS);
    debug = 1'b0;
    rd_chk(16'h1fff, ERASED_BYTE);
    rd_chk(16'h0000, ERASED_BYTE);
  endtask
  initial begin
    {rst_n, ctrl_wr, fhi_wr, flo_wr, debug, prog_wr, rd, ro_opt} = 8'h00;
    {data, page_sel, sect_prot, addr} = 40'h0;
    err_total = 0;
    check_count = 0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    s_lock_seq();
    s_program();
    s_erase();
    s_sector();
    s_readout();
    s_mass();
    print_verdict();
  end
endmodule
`default_nettype wire
